// >>> src/lpm_pkg.sv
/*
 * Constants, states and helper functions for the low-power mode manager.
 * Assumes a 125 MHz system clock; wake times are turned into cycle counts here.
 */
package lpm_pkg;

    localparam int unsigned CLK_MHZ = 125;

    // Requested low-power mode codes on mode_req_i
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_LP_RUN = 3'h2;
    localparam logic [2:0] MODE_LP_SLEEP = 3'h3;
    localparam logic [2:0] MODE_STOP = 3'h4;
    localparam logic [2:0] MODE_STANDBY = 3'h5;

    // Wake latencies
    localparam int unsigned SLEEP_WAKE_CPU_CYC = 6;
    localparam int unsigned LPSLEEP_WAKE_CPU_CYC = 7;
    localparam int unsigned LPRUN_WAKE_US = 3;
    localparam int unsigned STOP_WAKE_US = 5;
    localparam int unsigned STANDBY_WAKE_US = 65;
    localparam int unsigned STANDBY_EXIT_US = 60;
    localparam int unsigned LPRUN_WAKE_CYC = LPRUN_WAKE_US * CLK_MHZ;
    localparam int unsigned STOP_WAKE_CYC = STOP_WAKE_US * CLK_MHZ;
    localparam int unsigned STANDBY_WAKE_CYC = STANDBY_WAKE_US * CLK_MHZ;
    localparam int unsigned STANDBY_EXIT_CYC = STANDBY_EXIT_US * CLK_MHZ;

    // Core reset pulse length after Standby exit
    localparam int unsigned CORE_RST_CYC = 16;

    localparam int unsigned CNT_W = 14;
    localparam int unsigned N_WAKE_PINS = 3;

    // Voltage ranges on vrange_i
    localparam logic [1:0] VRANGE_1 = 2'h1;
    localparam logic [1:0] VRANGE_2 = 2'h2;
    localparam logic [1:0] VRANGE_3 = 2'h3;

    // Frequency thresholds in kHz
    localparam logic [15:0] F_MIN_KHZ = 16'h0020;
    localparam logic [15:0] F_4M2_KHZ = 16'h1068;
    localparam logic [15:0] F_8M_KHZ = 16'h1f40;
    localparam logic [15:0] F_16M_KHZ = 16'h3e80;
    localparam logic [15:0] F_32M_KHZ = 16'h7d00;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_SLEEP = 6'h02,
        ST_LOWPWR = 6'h04,
        ST_STOP = 6'h08,
        ST_STANDBY = 6'h10,
        ST_WAKE = 6'h20
    } lpm_state_t;

    // Wait states needed for a frequency in a voltage range
    function automatic logic lpm_wait_states(input logic [1:0] vr,
                                             input logic [15:0] f_khz);
        if (vr == VRANGE_1) begin
            return f_khz > F_16M_KHZ;
        end else if (vr == VRANGE_2) begin
            return f_khz > F_8M_KHZ;
        end else begin
            return 1'b0;
        end
    endfunction

    // Whether a frequency is legal in a voltage range
    function automatic logic lpm_freq_ok(input logic [1:0] vr,
                                         input logic [15:0] f_khz);
        logic [15:0] fmax;
        fmax = F_4M2_KHZ;
        if (vr == VRANGE_1) begin
            fmax = F_32M_KHZ;
        end else if (vr == VRANGE_2) begin
            fmax = F_16M_KHZ;
        end
        return (f_khz >= F_MIN_KHZ) && (f_khz <= fmax);
    endfunction

endpackage

// >>> src/lpm_freq_guard.sv
/*
 * Frequency-step checker: derives wait states and flags illegal
 * frequency changes. Assumes freq_khz_i and vrange_i come from logic on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module lpm_freq_guard
    import lpm_pkg::*;
#(
    parameter int unsigned STEP_GAP_US = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Frequency control
    input wire logic [1:0] vrange_i,
    input wire logic [15:0] freq_khz_i,
    input wire logic low_supply_i,
    // Results
    output logic wait_state_o,
    output logic freq_err_o
);

    localparam int unsigned GAP_CYC = STEP_GAP_US * CLK_MHZ;

    logic [15:0] prev_q, prev_d;
    logic [CNT_W-1:0] gap_q, gap_d;
    logic ws_q, ws_d;
    logic err_q, err_d;
    logic live_q, live_d;

    always_comb begin
        prev_d = freq_khz_i;
        live_d = 1'b1;
        gap_d = gap_q;
        ws_d = lpm_wait_states(vrange_i, freq_khz_i); // see R7 see R8 see R9
        err_d = !lpm_freq_ok(vrange_i, freq_khz_i);
        if (gap_q != '0) begin
            gap_d = gap_q - 1'b1;
        end
        if (live_q && freq_khz_i != prev_q) begin
            gap_d = CNT_W'(GAP_CYC);
            if (low_supply_i) begin
                // Step must stay below four times the old rate
                if ({2'b00, freq_khz_i} >= {prev_q, 2'b00}) begin
                    err_d = 1'b1; // see R5
                end
                if (gap_q != '0) begin
                    err_d = 1'b1; // see R6
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= F_MIN_KHZ;
            gap_q <= '0;
            ws_q <= 1'b0;
            err_q <= 1'b0;
            live_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            gap_q <= gap_d;
            ws_q <= ws_d;
            err_q <= err_d;
            live_q <= live_d;
        end
    end

    assign wait_state_o = ws_q;
    assign freq_err_o = err_q;

endmodule

`default_nettype wire

// >>> src/lpm_ctrl.sv
/*
 * Low-power mode manager: sequences Run, Sleep, low-power, Stop and
 * Standby, gates clocks, oscillators and the core regulator.
 * Assumes wake pins and the external reset pin are asynchronous.
 */
// Function
// R1: Standby turns off regulator, PLL and fast oscillators
// R2: Standby loses core state, keeps standby circuitry
// R3: Reset pin or wake edge exits Standby
// R4: Stop/Standby never halt calendar or watchdog
// R5: Low supply: new frequency below 4x old
// R6: Low supply: 5 us between frequency changes
// R7: Range 1: 32 MHz, wait state above 16
// R8: Range 2: 16 MHz, wait state above 8
// R9: Range 3: up to 4.2 MHz, zero waits
// R10: Fixed wake latencies back to Run per mode
// R11: Optional blocks need enable; unavailable ones stop
// R12: Stop: fast oscillator only for requesting peripheral
// R13: Serial receivers wake on start bit in Stop
// R14: Low-power receiver on slow clock, other fast
// R15: Bus slave address match wakes, keeps oscillator
// R16: Sleep halts only CPU; any interrupt wakes
// R17: Any external event line wakes from Stop
// R18: Standby exit restarts core with full reset
`timescale 1ns/10ps
`default_nettype none

module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int unsigned N_EVT = 16,
    parameter int unsigned STANDBY_EXIT_CYC_P = STANDBY_EXIT_CYC,
    parameter int unsigned STANDBY_WAKE_CYC_P = STANDBY_WAKE_CYC,
    parameter int unsigned STOP_WAKE_CYC_P = STOP_WAKE_CYC,
    parameter int unsigned LPRUN_WAKE_CYC_P = LPRUN_WAKE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Mode request from the CPU
    input wire logic [2:0] mode_req_i,
    input wire logic mode_go_i,
    input wire logic cpu_clk_en_i,
    // Wake sources
    input wire logic external_reset_pin_n_i,
    input wire logic [N_WAKE_PINS-1:0] wake_pin_i,
    input wire logic [N_EVT-1:0] external_event_lines_i,
    input wire logic periph_irq_i,
    input wire logic serial_start_i,
    input wire logic lp_serial_start_i,
    input wire logic bus_addr_match_i,
    // Fast oscillator requests in Stop
    input wire logic serial_osc_req_i,
    input wire logic bus_rx_active_i,
    input wire logic other_osc_req_i,
    // Software enables for optional blocks
    input wire logic [7:0] opt_en_i,
    input wire logic calendar_dis_i,
    input wire logic watchdog_dis_i,
    // Frequency control
    input wire logic [1:0] vrange_i,
    input wire logic [15:0] freq_khz_i,
    input wire logic low_supply_i,
    // Power and oscillator controls
    output logic core_reg_on_o,
    output logic pll_on_o,
    output logic multispeed_internal_osc_on_o,
    output logic fast_internal_osc_on_o,
    output logic slow_internal_osc_on_o,
    output logic fast_external_bypass_on_o,
    output logic slow_external_osc_on_o,
    // Clock gates
    output logic cpu_clk_en_o,
    output logic [7:0] block_clk_en_o,
    output logic serial_fast_clk_o,
    output logic lp_serial_slow_clk_o,
    output logic bus_fast_clk_o,
    // Status
    output logic core_rst_o,
    output logic core_retain_o,
    output logic [5:0] state_o,
    output logic wake_irq_o,
    output logic wait_state_o,
    output logic freq_err_o
);

    // Block slots in opt_en_i / block_clk_en_o
    localparam int unsigned B_DMA = 0;
    localparam int unsigned B_ADC = 1;
    localparam int unsigned B_TIM = 2;
    localparam int unsigned B_SPI = 3;
    localparam int unsigned B_SERIAL = 4;
    localparam int unsigned B_LPSER = 5;
    localparam int unsigned B_BUS = 6;
    localparam int unsigned B_LOW_POWER_TIMER = 7;
    localparam logic [7:0] STOP_OK = 8'hf0;
    localparam logic [7:0] LP_OK = 8'hbd;

    // Synchronisers for pin inputs
    logic [1:0] rst_pin_s_q, rst_pin_s_d;
    logic [N_WAKE_PINS-1:0] wk_s1_q, wk_s2_q, wk_s3_q;
    logic [N_WAKE_PINS-1:0] wk_s1_d, wk_s2_d, wk_s3_d;

    lpm_state_t st_q, st_d;
    logic [2:0] src_q, src_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [4:0] crst_q, crst_d;
    logic wake_q, wake_d;

    logic pin_rst;
    logic wake_edge;
    logic stop_wake;
    logic sleep_wake;

    always_comb begin
        rst_pin_s_d = {rst_pin_s_q[0], !external_reset_pin_n_i};
        wk_s1_d = wake_pin_i;
        wk_s2_d = wk_s1_q;
        wk_s3_d = wk_s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pin_s_q <= '0;
            wk_s1_q <= '0;
            wk_s2_q <= '0;
            wk_s3_q <= '0;
        end else begin
            rst_pin_s_q <= rst_pin_s_d;
            wk_s1_q <= wk_s1_d;
            wk_s2_q <= wk_s2_d;
            wk_s3_q <= wk_s3_d;
        end
    end

    assign pin_rst = rst_pin_s_q[1];
    assign wake_edge = |(wk_s2_q & ~wk_s3_q); // see R3
    assign stop_wake = (|external_event_lines_i) // see R17
        | serial_start_i | lp_serial_start_i // see R13
        | bus_addr_match_i; // see R15
    assign sleep_wake = periph_irq_i | (|external_event_lines_i); // see R16

    always_comb begin
        st_d = st_q;
        src_d = src_q;
        cnt_d = cnt_q;
        crst_d = crst_q;
        wake_d = 1'b0;
        if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (crst_q != '0) begin
            crst_d = crst_q - 1'b1;
        end
        case (st_q)
            ST_RUN: begin
                if (mode_go_i) begin
                    src_d = mode_req_i;
                    if (mode_req_i == MODE_SLEEP) begin
                        st_d = ST_SLEEP;
                    end else if (mode_req_i == MODE_LP_RUN ||
                                 mode_req_i == MODE_LP_SLEEP) begin
                        st_d = ST_LOWPWR;
                    end else if (mode_req_i == MODE_STOP) begin
                        st_d = ST_STOP;
                    end else if (mode_req_i == MODE_STANDBY) begin
                        st_d = ST_STANDBY;
                    end
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    st_d = ST_WAKE;
                    cnt_d = CNT_W'(SLEEP_WAKE_CPU_CYC); // see R10
                end
            end
            ST_LOWPWR: begin
                if (src_q == MODE_LP_RUN && mode_go_i &&
                    mode_req_i == MODE_RUN) begin
                    st_d = ST_WAKE;
                    cnt_d = CNT_W'(LPRUN_WAKE_CYC_P); // see R10
                end else if (src_q == MODE_LP_SLEEP && sleep_wake) begin
                    st_d = ST_WAKE;
                    cnt_d = CNT_W'(LPSLEEP_WAKE_CPU_CYC); // see R10
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    st_d = ST_WAKE;
                    wake_d = 1'b1;
                    cnt_d = CNT_W'(STOP_WAKE_CYC_P); // see R10
                end
            end
            ST_STANDBY: begin
                if (pin_rst || wake_edge) begin
                    st_d = ST_WAKE;
                    // Exit in 60 us; the core is back at 65 us
                    cnt_d = CNT_W'(STANDBY_EXIT_CYC_P); // see R3
                end
            end
            ST_WAKE: begin
                if (cnt_q <= CNT_W'(1)) begin
                    if (src_q == MODE_STANDBY) begin
                        // Regulator is up; pulse core reset, then wait out the rest
                        src_d = MODE_RUN;
                        cnt_d = CNT_W'(STANDBY_WAKE_CYC_P -
                                       STANDBY_EXIT_CYC_P);
                        crst_d = 5'(CORE_RST_CYC); // see R18
                    end else begin
                        st_d = ST_RUN;
                    end
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_RUN;
            src_q <= MODE_RUN;
            cnt_q <= '0;
            crst_q <= '0;
            wake_q <= 1'b0;
        end else begin
            st_q <= st_d;
            src_q <= src_d;
            cnt_q <= cnt_d;
            crst_q <= crst_d;
            wake_q <= wake_d;
        end
    end

    logic in_stop, in_stby, in_lp, stby_dark;
    logic fast_req;
    assign in_stop = (st_q == ST_STOP);
    assign in_stby = (st_q == ST_STANDBY);
    assign in_lp = (st_q == ST_LOWPWR);
    assign stby_dark = in_stby ||
        (st_q == ST_WAKE && src_q == MODE_STANDBY);
    // Peripheral requests only; drops once none is asserted
    assign fast_req = serial_osc_req_i | bus_rx_active_i
        | other_osc_req_i; // see R12 see R14 see R15

    always_comb begin
        core_reg_on_o = !stby_dark; // see R1
        pll_on_o = !(stby_dark || in_stop); // see R1
        multispeed_internal_osc_on_o = !(stby_dark || in_stop);
        fast_internal_osc_on_o = in_stop ? fast_req
            : !(stby_dark || in_lp); // see R11
        fast_external_bypass_on_o = !(stby_dark || in_stop);
        // Slow oscillators follow their own enables only
        slow_internal_osc_on_o = !watchdog_dis_i; // see R4
        slow_external_osc_on_o = !calendar_dis_i; // see R4
        cpu_clk_en_o = cpu_clk_en_i && (st_q == ST_RUN ||
            (in_lp && src_q == MODE_LP_RUN)); // see R16
        if (stby_dark) begin
            block_clk_en_o = '0; // see R11
        end else if (in_stop) begin
            block_clk_en_o = opt_en_i & STOP_OK; // see R11
        end else if (in_lp) begin
            block_clk_en_o = opt_en_i & LP_OK;
        end else begin
            block_clk_en_o = opt_en_i; // see R11
        end
        serial_fast_clk_o = in_stop ? (fast_req && serial_osc_req_i &&
            opt_en_i[B_SERIAL]) : block_clk_en_o[B_SERIAL];
        lp_serial_slow_clk_o = block_clk_en_o[B_LPSER]; // see R14
        bus_fast_clk_o = in_stop ? (fast_req && bus_rx_active_i &&
            opt_en_i[B_BUS]) : block_clk_en_o[B_BUS];
        // Core state lost while dark; held in reset until restart done
        core_retain_o = !stby_dark; // see R2
        core_rst_o = stby_dark || (crst_q != '0) || pin_rst; // see R2
        state_o = st_q;
        wake_irq_o = wake_q;
    end

    lpm_freq_guard u_guard (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .vrange_i(vrange_i),
        .freq_khz_i(freq_khz_i),
        .low_supply_i(low_supply_i),
        .wait_state_o(wait_state_o),
        .freq_err_o(freq_err_o)
    );

endmodule

`default_nettype wire

// >>> verif/lpm_ctrl_properties.sv
/*
 * Port assertions for lpm_ctrl, bound after the module.
 * Assumes one clock, clk_i, and the synchronous reset rst_i.
 */
`timescale 1ns/10ps
`default_nettype none

module lpm_ctrl_properties
    import lpm_pkg::*;
#(
    parameter int unsigned N_EVT = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wake sources
    input wire logic [N_WAKE_PINS-1:0] wake_pin_i,
    input wire logic external_reset_pin_n_i,
    input wire logic [N_EVT-1:0] external_event_lines_i,
    input wire logic periph_irq_i,
    input wire logic serial_start_i,
    input wire logic lp_serial_start_i,
    input wire logic bus_addr_match_i,
    // Frequency control
    input wire logic [1:0] vrange_i,
    input wire logic [15:0] freq_khz_i,
    input wire logic low_supply_i,
    // Design outputs
    input wire logic core_reg_on_o,
    input wire logic pll_on_o,
    input wire logic fast_internal_osc_on_o,
    input wire logic cpu_clk_en_o,
    input wire logic [7:0] block_clk_en_o,
    input wire logic core_rst_o,
    input wire logic [5:0] state_o,
    input wire logic wake_irq_o,
    input wire logic wait_state_o,
    input wire logic freq_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic stop_src;
    assign stop_src = (|external_event_lines_i) | serial_start_i
                    | lp_serial_start_i | bus_addr_match_i;

    AST_STANDBY_DARK:
        assert property (state_o == ST_STANDBY |-> !core_reg_on_o
            && !pll_on_o && !fast_internal_osc_on_o)
        else $error("supply or clock on in standby");
    AST_STOP_GATES:
        assert property (state_o == ST_STOP |-> !cpu_clk_en_o
            && block_clk_en_o[3:0] == 4'h0)
        else $error("unavailable block clocked in stop");
    AST_STOP_WAKE:
        assert property (state_o == ST_STOP && stop_src
            |=> state_o == ST_WAKE && wake_irq_o)
        else $error("stop did not wake on a source");
    AST_SLEEP_WAKE:
        assert property (state_o == ST_SLEEP && periph_irq_i
            |-> ##[1:8] state_o == ST_RUN)
        else $error("sleep did not return to run");
    AST_STANDBY_EXIT:
        assert property (state_o == ST_STANDBY && (!external_reset_pin_n_i
            || (wake_pin_i & ~$past(wake_pin_i)) != '0)
            |-> ##[1:4] state_o == ST_WAKE)
        else $error("standby ignored a wake cause");
    AST_CORE_RST_LEN:
        assert property ($rose(core_reg_on_o) && state_o == ST_WAKE
            |-> core_rst_o [*8] ##1 core_rst_o [*8] ##1 !core_rst_o)
        else $error("core reset pulse length wrong");
    AST_WS_ONE:
        assert property ((vrange_i == VRANGE_1 && freq_khz_i > F_16M_KHZ)
            || (vrange_i == VRANGE_2 && freq_khz_i > F_8M_KHZ)
            |=> wait_state_o)
        else $error("wait state missing");
    AST_WS_ZERO:
        assert property (vrange_i == VRANGE_3
            || (vrange_i == VRANGE_1 && freq_khz_i <= F_16M_KHZ)
            || (vrange_i == VRANGE_2 && freq_khz_i <= F_8M_KHZ)
            |=> !wait_state_o)
        else $error("wait state not needed");
    AST_RANGE3_ERR:
        assert property (vrange_i == VRANGE_3 && freq_khz_i > F_4M2_KHZ
            |=> freq_err_o)
        else $error("range 3 overspeed not flagged");
    AST_STEP_4X:
        assert property (low_supply_i && freq_khz_i != $past(freq_khz_i)
            && {2'h0, freq_khz_i} >= {$past(freq_khz_i), 2'h0}
            |=> freq_err_o)
        else $error("fourfold step not flagged");

    COV_STOP: cover property (state_o == ST_STOP ##1 state_o == ST_WAKE);
    COV_CORE_RST: cover property ($rose(core_rst_o));
    COV_SLEEP: cover property (state_o == ST_SLEEP ##1 state_o == ST_RUN);
endmodule

bind lpm_ctrl lpm_ctrl_properties #(.N_EVT(N_EVT)) chk_u (.*);

`default_nettype wire

// >>> verif/lpm_far_side.sv
/*
 * Far-side model: wake pins, reset pin, event line, peripheral wakes,
 * oscillator requests and CPU frequency. Assumes the bench calls its
 * tasks; every change lands on a falling edge.
 */
`timescale 1ns/10ps
`default_nettype none

module lpm_far_side (
    // Clock
    input wire logic clk_i,
    // Wake sources
    output logic [2:0] wake_pin_o,
    output logic reset_pin_n_o,
    output logic [15:0] event_o,
    output logic irq_o,
    output logic [2:0] start_o,
    // Requests and frequency
    output logic [2:0] osc_req_o,
    output logic [15:0] freq_khz_o
);
    // Sources: 0-2 wake pins, 3 reset pin, 4 event, 5 irq, 6-8 starts
    logic [8:0] src = 9'h000;
    logic [2:0] req = 3'h0;
    logic [15:0] freq = 16'h0fa0;

    assign wake_pin_o = src[2:0];
    assign reset_pin_n_o = !src[3];
    assign event_o = {10'h000, src[4], 5'h00};
    assign irq_o = src[5];
    assign start_o = src[8:6];
    assign osc_req_o = req;
    assign freq_khz_o = freq;

    task automatic drive(input int s, input logic v);
        @(negedge clk_i);
        src[s] = v;
    endtask

    task automatic set_req(input logic [2:0] r);
        @(negedge clk_i);
        req = r;
    endtask

    // Callers space changes by gap cycles; 700 is past the 5 us gap
    task automatic step_freq(input logic [15:0] f, input int gap);
        repeat (gap) @(negedge clk_i);
        freq = f;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb_low_power_mode_manager.sv
/*
 * Self-checking bench for lpm_ctrl with shortened wake counts.
 * Assumes lpm_far_side drives the wake sources and the frequency.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_low_power_mode_manager
    import lpm_pkg::*;
;
    localparam int SB_WAKE = 40;
    localparam int STOP_W = 10;
    localparam int LPRUN_W = 10;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] mode_req_i = MODE_RUN;
    logic mode_go_i = 1'b0;
    logic cpu_clk_en_i = 1'b1;
    logic [7:0] opt_en_i = 8'hff;
    logic calendar_dis_i = 1'b0;
    logic watchdog_dis_i = 1'b0;
    logic [1:0] vrange_i = VRANGE_1;
    logic low_supply_i = 1'b0;
    logic [2:0] wake_pin_i, start, req;
    logic [15:0] external_event_lines_i, freq_khz_i;
    logic external_reset_pin_n_i, periph_irq_i, serial_start_i;
    logic lp_serial_start_i, bus_addr_match_i, serial_osc_req_i;
    logic bus_rx_active_i, other_osc_req_i, core_reg_on_o, pll_on_o;
    logic multispeed_internal_osc_on_o, fast_internal_osc_on_o;
    logic slow_internal_osc_on_o, fast_external_bypass_on_o;
    logic slow_external_osc_on_o, cpu_clk_en_o, serial_fast_clk_o;
    logic lp_serial_slow_clk_o, bus_fast_clk_o, core_rst_o;
    logic core_retain_o, wake_irq_o, wait_state_o, freq_err_o;
    logic [7:0] block_clk_en_o;
    logic [5:0] state_o;
    int n_errors = 0;
    int n_tests = 0;

    assign {bus_addr_match_i, lp_serial_start_i, serial_start_i} = start;
    assign {other_osc_req_i, bus_rx_active_i, serial_osc_req_i} = req;

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    lpm_ctrl #(
        .STANDBY_EXIT_CYC_P(20),
        .STANDBY_WAKE_CYC_P(SB_WAKE),
        .STOP_WAKE_CYC_P(STOP_W),
        .LPRUN_WAKE_CYC_P(LPRUN_W)
    ) dut_u (.*);

    lpm_far_side far_u (
        .clk_i(clk_i),
        .wake_pin_o(wake_pin_i),
        .reset_pin_n_o(external_reset_pin_n_i),
        .event_o(external_event_lines_i),
        .irq_o(periph_irq_i),
        .start_o(start),
        .osc_req_o(req),
        .freq_khz_o(freq_khz_i)
    );

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic go(input logic [2:0] m);
        @(negedge clk_i);
        mode_req_i = m;
        mode_go_i = 1'b1;
        @(negedge clk_i);
        mode_go_i = 1'b0;
    endtask

    // Counts cycles until Run, and how many of them hold core reset with the regulator on
    task automatic to_run(input int lim, output int n, output int r);
        n = 0;
        r = 0;
        while (state_o !== ST_RUN) begin
            if (n == lim) begin
                n_errors++;
                $display("[FAIL] %0t no return to run", $time);
                complete_run();
            end
            n++;
            r += int'({core_rst_o, core_reg_on_o} === 2'b11);
            @(negedge clk_i);
        end
    endtask

    task automatic t_stop();
        int s, n, r;
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 4 : k + 5;
            go(MODE_STOP);
            check({state_o, cpu_clk_en_o, pll_on_o, block_clk_en_o},
                  {ST_STOP, 2'b00, 8'hf0}, "stop gates");
            if (k == 0) begin
                far_u.set_req(3'h1);
                @(negedge clk_i);
                check({fast_internal_osc_on_o, serial_fast_clk_o,
                       bus_fast_clk_o}, 3'h6, "serial req");
                far_u.set_req(3'h6);
                @(negedge clk_i);
                check({fast_internal_osc_on_o, serial_fast_clk_o,
                       bus_fast_clk_o}, 3'h5, "bus req");
                far_u.set_req(3'h0);
                @(negedge clk_i);
                check(fast_internal_osc_on_o, 1'b0, "req drop");
            end
            far_u.drive(s, 1'b1);
            @(negedge clk_i);
            check({state_o, wake_irq_o}, {ST_WAKE, 1'b1}, "wake");
            far_u.drive(s, 1'b0);
            to_run(100, n, r);
            check(n + 1, STOP_W, "stop wake time");
        end
        $display("stop test done");
    endtask

    task automatic t_sleep();
        int n, r;
        opt_en_i = 8'h5a;
        for (int k = 0; k < 2; k++) begin
            go(k == 0 ? MODE_SLEEP : MODE_LP_SLEEP);
            check({state_o, cpu_clk_en_o, block_clk_en_o}, k == 0 ?
                  {ST_SLEEP, 9'h05a} : {ST_LOWPWR, 9'h018}, "gates");
            far_u.drive(5, 1'b1);
            to_run(20, n, r);
            check(n, 1 + (k == 0 ? SLEEP_WAKE_CPU_CYC :
                  LPSLEEP_WAKE_CPU_CYC), "sleep wake time");
            far_u.drive(5, 1'b0);
        end
        go(MODE_LP_RUN);
        check({state_o, cpu_clk_en_o, fast_internal_osc_on_o},
              {ST_LOWPWR, 2'b10}, "lp run");
        go(MODE_RUN);
        to_run(50, n, r);
        check(n, LPRUN_W, "lp run exit time");
        opt_en_i = 8'hff;
        $display("sleep test done");
    endtask

    task automatic t_standby();
        int n, r;
        for (int s = 0; s < 4; s++) begin
            go(MODE_STANDBY);
            check({core_reg_on_o, pll_on_o, multispeed_internal_osc_on_o,
                   fast_internal_osc_on_o, fast_external_bypass_on_o}, 5'h00,
                  "standby dark");
            check({core_retain_o, slow_internal_osc_on_o,
                   slow_external_osc_on_o}, 3'h3, "standby keep");
            far_u.drive(s, 1'b1);
            repeat (3) @(negedge clk_i);
            far_u.drive(s, 1'b0);
            to_run(SB_WAKE + 40, n, r);
            check(n + 1, SB_WAKE, "standby exit time");
            if (s < 3) begin
                check(r, CORE_RST_CYC, "core reset pulse");
            end
        end
        @(negedge clk_i);
        calendar_dis_i = 1'b1;
        watchdog_dis_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check({slow_internal_osc_on_o, slow_external_osc_on_o}, 2'h0,
              "slow disable");
        calendar_dis_i = 1'b0;
        watchdog_dis_i = 1'b0;
        $display("standby test done");
    endtask

    task automatic t_freq();
        logic [19:0] tab [10] = '{
            {VRANGE_1, 16'h3e80, 2'b00}, {VRANGE_1, 16'h3e81, 2'b10},
            {VRANGE_1, 16'h7d00, 2'b10}, {VRANGE_1, 16'h7d01, 2'b11},
            {VRANGE_2, 16'h1f40, 2'b00}, {VRANGE_2, 16'h1f41, 2'b10},
            {VRANGE_2, 16'h3e81, 2'b11}, {VRANGE_3, 16'h1068, 2'b00},
            {VRANGE_3, 16'h1069, 2'b01}, {VRANGE_3, 16'h001f, 2'b01}};
        for (int i = 0; i < 10; i++) begin
            far_u.step_freq(tab[i][17:2], 1);
            vrange_i = tab[i][19:18];
            @(negedge clk_i);
            check({wait_state_o, freq_err_o}, tab[i][1:0], "range");
        end
        low_supply_i = 1'b1;
        vrange_i = VRANGE_1;
        far_u.step_freq(16'h0fa0, 1);
        far_u.step_freq(16'h3e80, 700);
        @(negedge clk_i);
        check(freq_err_o, 1'b1, "fourfold step");
        far_u.step_freq(16'h1f40, 700);
        @(negedge clk_i);
        check(freq_err_o, 1'b0, "spaced step down");
        far_u.step_freq(16'h2328, 2);
        @(negedge clk_i);
        check(freq_err_o, 1'b1, "steps too close");
        far_u.step_freq(16'h4e20, 700);
        @(negedge clk_i);
        check(freq_err_o, 1'b0, "spaced step up");
        low_supply_i = 1'b0;
        $display("frequency test done");
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        t_stop();
        t_sleep();
        t_standby();
        t_freq();
        complete_run();
    end
endmodule

`default_nettype wire
